// ===== src/sbit_pkg.sv
// Package: register map, field positions, reset values and timing for the interval timer
package sbit_pkg;
    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] COUNT_OFS = 12'h004;
    localparam logic [11:0] PERIOD_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00C;
    localparam logic [11:0] MASK_OFS = 12'h010;
    localparam logic [11:0] PRIO_OFS = 12'h014;
    // Control field positions
    localparam int TON_BIT = 15;
    localparam int SIDL_BIT = 13;
    localparam int ECS_HI = 9;
    localparam int ECS_LO = 8;
    localparam int GATE_BIT = 6;
    localparam int PS_HI = 5;
    localparam int PS_LO = 4;
    localparam int SYNC_BIT = 2;
    localparam int CS_BIT = 1;
    // Writable control bits
    localparam logic [15:0] CTRL_MASK = 16'hA376;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [1:0] STATUS_RST = 2'h0;
    localparam logic [2:0] PRIO_RST = 3'h0;
    // Status bits
    localparam int ST_MATCH = 0;
    localparam int ST_GATE = 1;
    // Extended source codes
    localparam logic [1:0] SRC_SECONDARY_OSC = 2'h0;
    localparam logic [1:0] SRC_PIN = 2'h1;
    localparam logic [1:0] SRC_LOW_POWER_RC_OSC = 2'h2;
    localparam logic [1:0] SRC_GEN = 2'h3;
    // Prescale terminal counts
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3F;
    localparam logic [7:0] PS_DIV256 = 8'hFF;
endpackage

// ===== src/sbit_timer.sv
// Top module: 16-bit interval timer with APB register slave
`timescale 1ns/1ps
module sbit_timer #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic secondaryOsc,
    input wire logic lowPowerRcOsc,
    input wire logic timerClockPin,
    input wire logic genericTimerClockInput,
    input wire logic gateIn,
    input wire logic idleMode,
    output logic timerIrq,
    output logic [2:0] timerIrqPriority
);
    // ==========================================
    // Input synchronisers
    logic [2:0] extSync_reg;
    logic [2:0] extSync_next;
    logic [2:0] gateSync_reg;
    logic [2:0] gateSync_next;
    logic extRaw;
    logic [1:0] ecs;
    logic extSyncLevel_reg;
    logic extSyncLevel_next;
    logic gateLevel_reg;
    logic gateLevel_next;
    logic extRawPrev_reg;
    logic extRawPrev_next;
    // ==========================================
    // Registers
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] period_reg;
    logic [WIDTH-1:0] period_next;
    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic [2:0] prio_reg;
    logic [2:0] prio_next;
    logic [7:0] ps_reg;
    logic [7:0] ps_next;
    logic half_reg;
    logic half_next;
    logic matchPend_reg;
    logic matchPend_next;
    logic [31:0] prdata_next;
    logic pready_next;
    logic timerIrq_next;
    logic acc;
    logic wr;
    logic rd;
    logic rdSetup;
    logic wrCtrl;
    logic wrCount;
    logic matchSet;
    logic [31:0] rdWord;
    logic srcTick;
    logic countTick;
    logic running;
    logic gateFall;
    logic [7:0] psLimit;

    function automatic logic [7:0] ps_terminal(input logic [1:0] sel);
        case (sel)
            2'h0: ps_terminal = sbit_pkg::PS_DIV1;
            2'h1: ps_terminal = sbit_pkg::PS_DIV8;
            2'h2: ps_terminal = sbit_pkg::PS_DIV64;
            default: ps_terminal = sbit_pkg::PS_DIV256;
        endcase
    endfunction

    assign ecs = ctrl_reg[sbit_pkg::ECS_HI:sbit_pkg::ECS_LO];

    // ==========================================
    // Clock source and tick generation
    always_comb
    begin
        case (ecs)
            sbit_pkg::SRC_SECONDARY_OSC: extRaw = secondaryOsc;
            sbit_pkg::SRC_PIN: extRaw = timerClockPin;
            sbit_pkg::SRC_LOW_POWER_RC_OSC: extRaw = lowPowerRcOsc;
            default: extRaw = genericTimerClockInput;
        endcase
        extSync_next = {extSync_reg[1:0], extRaw};
        gateSync_next = {gateSync_reg[1:0], gateIn};
        // A change counts once the second and third stages agree
        extSyncLevel_next = (extSync_reg[1] == extSync_reg[2]) ? extSync_reg[2] : extSyncLevel_reg;
        gateLevel_next = (gateSync_reg[1] == gateSync_reg[2]) ? gateSync_reg[2] : gateLevel_reg;
        // Unsynchronised mode takes the second register stage, extSync_reg[1]: lower latency, more jitter
        extRawPrev_next = extSync_reg[1];
        running = ctrl_reg[sbit_pkg::TON_BIT]
            && !(ctrl_reg[sbit_pkg::SIDL_BIT] && idleMode);
        half_next = running ? ~half_reg : 1'b0;
        gateFall = gateLevel_reg && !gateLevel_next;
        if (ctrl_reg[sbit_pkg::CS_BIT])
        begin
            if (ctrl_reg[sbit_pkg::SYNC_BIT])
                srcTick = extSyncLevel_next && !extSyncLevel_reg;
            else
                srcTick = extSync_reg[1] && !extRawPrev_reg;
        end
        else if (ctrl_reg[sbit_pkg::GATE_BIT])
            srcTick = half_reg && gateLevel_reg;
        else
            srcTick = half_reg;
        srcTick = srcTick && running;
        psLimit = ps_terminal(ctrl_reg[sbit_pkg::PS_HI:sbit_pkg::PS_LO]);
        countTick = srcTick && (ps_reg >= psLimit);
    end

    // ==========================================
    // Bus decode and read word select
    always_comb
    begin
        acc = psel && penable;
        wr = acc && pwrite;
        rd = acc && !pwrite;
        rdSetup = psel && !penable && !pwrite;
        wrCtrl = wr && paddr == sbit_pkg::CTRL_OFS;
        wrCount = wr && paddr == sbit_pkg::COUNT_OFS;
        case (paddr)
            sbit_pkg::CTRL_OFS: rdWord = {16'h0000, ctrl_reg};
            sbit_pkg::COUNT_OFS: rdWord = 32'(count_reg);
            sbit_pkg::PERIOD_OFS: rdWord = 32'(period_reg);
            sbit_pkg::STATUS_OFS: rdWord = {30'h0, status_reg};
            sbit_pkg::MASK_OFS: rdWord = {30'h0, mask_reg};
            sbit_pkg::PRIO_OFS: rdWord = {29'h0, prio_reg};
            default: rdWord = 32'h00000000;
        endcase
    end

    // ==========================================
    // Prescaler and counter
    always_comb
    begin
        count_next = count_reg;
        ps_next = ps_reg;
        matchPend_next = matchPend_reg;
        matchSet = 1'b0;
        if (srcTick)
            ps_next = countTick ? 8'h00 : ps_reg + 8'h01;
        if (countTick)
        begin
            if (matchPend_reg)
            begin
                count_next = '0;
                matchPend_next = 1'b0;
            end
            else
                count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
        // Any control write while running restarts the divider, whatever the new value
        if (wrCtrl && ctrl_reg[sbit_pkg::TON_BIT])
            ps_next = 8'h00;
        // Writing the count cancels a pending clear, so the written value is kept
        if (wrCount)
        begin
            count_next = pwdata[WIDTH-1:0];
            matchPend_next = 1'b0;
        end
        // Match flagged as the count reaches period; clear happens on the next tick
        if (countTick && !matchPend_reg && count_next == period_reg)
        begin
            matchPend_next = 1'b1;
            matchSet = 1'b1;
        end
    end

    // ==========================================
    // Register file and interrupt
    always_comb
    begin
        ctrl_next = ctrl_reg;
        period_next = period_reg;
        mask_next = mask_reg;
        prio_next = prio_reg;
        status_next = status_reg;
        prdata_next = prdata;
        pready_next = 1'b1;
        // Clear only what the read returned, so an event after the setup edge survives
        if (rd && paddr == sbit_pkg::STATUS_OFS)
            status_next = status_reg & ~prdata[1:0];
        if (wr)
        begin
            case (paddr)
                sbit_pkg::CTRL_OFS: ctrl_next = pwdata[15:0] & sbit_pkg::CTRL_MASK;
                sbit_pkg::PERIOD_OFS: period_next = pwdata[WIDTH-1:0];
                sbit_pkg::MASK_OFS: mask_next = pwdata[1:0];
                sbit_pkg::PRIO_OFS: prio_next = pwdata[2:0];
                default: ;
            endcase
        end
        // Events are applied after the read clear, so a set in the same cycle wins
        if (matchSet)
            status_next[sbit_pkg::ST_MATCH] = 1'b1;
        if (gateFall && running && !ctrl_reg[sbit_pkg::CS_BIT] && ctrl_reg[sbit_pkg::GATE_BIT])
            status_next[sbit_pkg::ST_GATE] = 1'b1;
        // Read data is taken in the setup phase so that it stands through the access phase
        if (rdSetup)
            prdata_next = rdWord;
        timerIrq_next = |(status_next & mask_next);
    end

    // ==========================================
    // Synchroniser flops
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            extSync_reg <= 3'h0;
            gateSync_reg <= 3'h0;
            extSyncLevel_reg <= 1'b0;
            gateLevel_reg <= 1'b0;
            extRawPrev_reg <= 1'b0;
        end
        else
        begin
            extSync_reg <= extSync_next;
            gateSync_reg <= gateSync_next;
            extSyncLevel_reg <= extSyncLevel_next;
            gateLevel_reg <= gateLevel_next;
            extRawPrev_reg <= extRawPrev_next;
        end
    end

    // ==========================================
    // Counter flops
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count_reg <= sbit_pkg::COUNT_RST;
            ps_reg <= 8'h00;
            half_reg <= 1'b0;
            matchPend_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            ps_reg <= ps_next;
            half_reg <= half_next;
            matchPend_reg <= matchPend_next;
        end
    end

    // ==========================================
    // Register and bus output flops
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_reg <= sbit_pkg::CTRL_RST;
            period_reg <= sbit_pkg::PERIOD_RST;
            status_reg <= sbit_pkg::STATUS_RST;
            mask_reg <= 2'h0;
            prio_reg <= sbit_pkg::PRIO_RST;
            prdata <= 32'h00000000;
            pready <= 1'b1;
            pslverr <= 1'b0;
            timerIrq <= 1'b0;
            timerIrqPriority <= sbit_pkg::PRIO_RST;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            period_reg <= period_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            prio_reg <= prio_next;
            prdata <= prdata_next;
            pready <= pready_next;
            pslverr <= 1'b0;
            timerIrq <= timerIrq_next;
            timerIrqPriority <= prio_next;
        end
    end
endmodule

// ===== tb/sbit_timer_chk.sv
// Checker: bus and interrupt relations of the interval timer
`timescale 1ns/1ps
// ==========
// Checker module
module sbit_timer_chk #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic secondaryOsc,
    input wire logic lowPowerRcOsc,
    input wire logic timerClockPin,
    input wire logic genericTimerClockInput,
    input wire logic gateIn,
    input wire logic idleMode,
    input wire logic timerIrq,
    input wire logic [2:0] timerIrqPriority
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    wire logic rdAcc = psel && penable && !pwrite;
    wire logic wrAcc = psel && penable && pwrite;
    wire logic rdSetup = psel && !penable && !pwrite;
    // ==========
    // Assertions
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_no_slverr: assert property (!pslverr) else $error("pslverr high");
    chk_ctrl_zero: assert property (rdAcc && paddr == sbit_pkg::CTRL_OFS |->
        (prdata & ~{16'h0, sbit_pkg::CTRL_MASK}) == 32'h0) else $error("ctrl spare bits");
    chk_unmapped_zero: assert property (rdAcc && paddr == 12'h100 |-> prdata == 32'h0)
        else $error("unmapped read");
    chk_prdata_hold: assert property (!rdSetup |=> $stable(prdata)) else $error("prdata moved");
    chk_prio_copy: assert property (wrAcc && paddr == sbit_pkg::PRIO_OFS |->
        ##2 timerIrqPriority == $past(pwdata[2:0], 2)) else $error("priority copy");
    chk_mask_off: assert property (wrAcc && paddr == sbit_pkg::MASK_OFS && pwdata == 32'h0
        ##1 !(wrAcc && paddr == sbit_pkg::MASK_OFS) |=> !timerIrq) else $error("masked irq");
    chk_ctrl_rw: assert property (wrAcc && paddr == sbit_pkg::CTRL_OFS ##1 !psel
        ##1 (psel && !penable && !pwrite && paddr == sbit_pkg::CTRL_OFS) ##1 rdAcc
        |-> prdata[15:0] == ($past(pwdata[15:0], 3) & sbit_pkg::CTRL_MASK))
        else $error("ctrl readback");
    cover property ($rose(timerIrq));
    cover property (rdAcc && paddr == sbit_pkg::STATUS_OFS);
    cover property (wrAcc && paddr == sbit_pkg::CTRL_OFS && pwdata[15]);
endmodule
bind sbit_timer sbit_timer_chk #(.WIDTH(WIDTH)) i_sbit_timer_chk (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .secondaryOsc(secondaryOsc), .lowPowerRcOsc(lowPowerRcOsc), .timerClockPin(timerClockPin),
    .genericTimerClockInput(genericTimerClockInput), .gateIn(gateIn), .idleMode(idleMode),
    .timerIrq(timerIrq), .timerIrqPriority(timerIrqPriority)
);

// ===== tb/sbit_timer_tb.sv
// Testbench: register, counting and interrupt checks of the interval timer
`timescale 1ns/1ps
// ==========
// Bench top
module sbit_timer_tb;
    logic sysClk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic gateIn = 1'b0;
    logic idleMode = 1'b0;
    logic [3:0] extSrc = 4'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, timerIrq;
    logic [2:0] timerIrqPriority;
    int mismatches = 0, testsRun = 0, div, n;
    sbit_timer i_sbit_timer (.sys_clk(sysClk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .secondaryOsc(extSrc[0]), .timerClockPin(extSrc[1]),
        .lowPowerRcOsc(extSrc[2]), .genericTimerClockInput(extSrc[3]), .gateIn(gateIn),
        .idleMode(idleMode), .timerIrq(timerIrq), .timerIrqPriority(timerIrqPriority));
    always #5 sysClk = ~sysClk;
    // ==========
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic inr(input logic [31:0] seen, input int lo, input int hi);
        check({31'h0, seen >= lo && seen <= hi}, 32'h1);
    endtask
    // Held until pready is seen high; read data is taken at that same edge
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sysClk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sysClk);
        penable <= 1'b1;
        @(posedge sysClk);
        while (pready !== 1'b1) @(posedge sysClk);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rv, e);
    endtask
    task automatic run_for(input logic [31:0] c, input int cyc);
        wr(sbit_pkg::COUNT_OFS, 32'h0);
        wr(sbit_pkg::CTRL_OFS, c);
        repeat (cyc) @(posedge sysClk);
        wr(sbit_pkg::CTRL_OFS, 32'h0);
        bus(1'b0, sbit_pkg::COUNT_OFS, 32'h0);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========
    // Sequence
    initial
    begin
        repeat (16) @(posedge sysClk);
        nrst <= 1'b1;
        rdc(sbit_pkg::CTRL_OFS, 32'h0);
        rdc(sbit_pkg::PERIOD_OFS, 32'hFFFF);
        rdc(sbit_pkg::STATUS_OFS, 32'h0);
        wr(sbit_pkg::CTRL_OFS, 32'hFFFFFFFF);
        rdc(sbit_pkg::CTRL_OFS, 32'hA376);
        wr(sbit_pkg::CTRL_OFS, 32'h0);
        wr(12'h100, 32'h1234);
        rdc(12'h100, 32'h0);
        wr(sbit_pkg::COUNT_OFS, 32'hCAFE);
        rdc(sbit_pkg::COUNT_OFS, 32'hCAFE);
        wr(sbit_pkg::PRIO_OFS, 32'h5);
        rdc(sbit_pkg::PRIO_OFS, 32'h5);
        for (int k = 0; k < 4; k++)
        begin
            div = (k == 0) ? 1 : (k == 1) ? 8 : (k == 2) ? 64 : 256;
            run_for(32'h8000 | (k << 4), 20 * div);
            inr(rv, 9, 12);
        end
        wr(sbit_pkg::COUNT_OFS, 32'h0);
        repeat (20) wr(sbit_pkg::CTRL_OFS, 32'h8010);
        rdc(sbit_pkg::COUNT_OFS, 32'h0);
        wr(sbit_pkg::CTRL_OFS, 32'h0);
        @(posedge sysClk) idleMode <= 1'b1;
        run_for(32'hA000, 40);
        check(rv, 32'h0);
        run_for(32'h8000, 40);
        inr(rv, 19, 23);
        @(posedge sysClk) idleMode <= 1'b0;
        wr(sbit_pkg::COUNT_OFS, 32'h0);
        wr(sbit_pkg::MASK_OFS, 32'h2);
        wr(sbit_pkg::CTRL_OFS, 32'h8040);
        repeat (30) @(posedge sysClk);
        rdc(sbit_pkg::COUNT_OFS, 32'h0);
        @(posedge sysClk) gateIn <= 1'b1;
        repeat (40) @(posedge sysClk);
        gateIn <= 1'b0;
        repeat (10) @(posedge sysClk);
        check({31'h0, timerIrq}, 32'h1);
        wr(sbit_pkg::CTRL_OFS, 32'h0);
        bus(1'b0, sbit_pkg::COUNT_OFS, 32'h0);
        inr(rv, 18, 24);
        rdc(sbit_pkg::STATUS_OFS, 32'h2);
        wr(sbit_pkg::MASK_OFS, 32'h0);
        wr(sbit_pkg::PERIOD_OFS, 32'h4);
        run_for(32'h8000, 40);
        inr(rv, 0, 4);
        check({31'h0, timerIrq}, 32'h0);
        rdc(sbit_pkg::STATUS_OFS, 32'h1);
        wr(sbit_pkg::MASK_OFS, 32'h1);
        wr(sbit_pkg::COUNT_OFS, 32'h0);
        wr(sbit_pkg::CTRL_OFS, 32'h8000);
        for (n = 0; timerIrq !== 1'b1 && n < 50; n++) @(posedge sysClk);
        inr(n, 6, 13);
        wr(sbit_pkg::CTRL_OFS, 32'h0);
        rdc(sbit_pkg::STATUS_OFS, 32'h1);
        wr(sbit_pkg::PERIOD_OFS, 32'hFFFF);
        // Unselected sources pulse half as often, so a wrong pick shows in the count
        for (int k = 0; k < 4; k++)
        begin
            wr(sbit_pkg::COUNT_OFS, 32'h0);
            wr(sbit_pkg::CTRL_OFS, 32'h8002 | (k << 8) | ((k & 1) << 2));
            for (int j = 0; j < 6; j++)
            begin
                @(posedge sysClk) extSrc <= j[0] ? 4'hF : 4'(1 << k);
                repeat (4) @(posedge sysClk);
                extSrc <= 4'h0;
                repeat (4) @(posedge sysClk);
            end
            repeat (10) @(posedge sysClk);
            wr(sbit_pkg::CTRL_OFS, 32'h0);
            rdc(sbit_pkg::COUNT_OFS, 32'h6);
        end
        end_of_test();
    end
    initial
    begin
        repeat (40000) @(posedge sysClk);
        mismatches++;
        end_of_test();
    end
endmodule
